// ---- rtl/lpr_pkg.sv ----
// Package: register map, field layout, timing and carriers of the result block
package lpr_pkg;
  localparam logic [7:0] ADDR_AMB_HI  = 8'h85;
  localparam logic [7:0] ADDR_AMB_LO  = 8'h86;
  localparam logic [7:0] ADDR_PRX_HI  = 8'h87;
  localparam logic [7:0] ADDR_PRX_LO  = 8'h88;
  localparam logic [7:0] ADDR_FREQ    = 8'h89;
  localparam logic [7:0] ADDR_MODT    = 8'h8A;
  localparam logic [7:0] ADDR_IRLVL   = 8'h8B;
  localparam logic [1:0] FREQ_RST     = 2'h2;
  localparam logic [7:0] MODT_RST     = 8'h00;
  localparam int         FREQ_LSB     = 0;
  localparam int         DEAD_LSB     = 0;
  localparam int         DELAY_LSB    = 5;
  // Emitter half period in device clocks for code 0; each code step doubles it
  localparam int         CLK_HZ       = 25000000;
  localparam int         F0_HZ        = 3125000;
  localparam logic [7:0] HALF_F0      = 8'(CLK_HZ / F0_HZ / 2);
  localparam logic [7:0] MODT_BEST    = 8'h81;

  typedef struct packed {
    logic       vld;
    logic [15:0] val;
  } lpr_result_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       addr_phase;
    logic [7:0] wdata;
  } lpr_busreq_s;
endpackage : lpr_pkg

// ---- rtl/lpr_emit.sv ----
// Emitter square wave generator with delayed, dead-time blanked evaluation window
`timescale 1ns/1ns
`default_nettype none
module lpr_emit (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [1:0] i_freq,
  input  wire logic [2:0] i_delay,
  input  wire logic [2:0] i_dead,
  output logic            o_led,
  output logic            o_eval
);
  import lpr_pkg::*;
  logic [7:0] half_cnt_q;
  logic [7:0] half_len;
  logic [7:0] pos;
  logic [7:0] led_hist_q;
  logic       ref_led;
  logic       led_q;

  // Half period doubles per code step
  assign half_len = HALF_F0 << i_freq;

  // Square wave at the chosen test frequency while measuring
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_cnt_q <= 8'h00;
      led_q      <= 1'b0;
    end else if (!i_run) begin
      half_cnt_q <= 8'h00;
      led_q      <= 1'b0;
    end else if (half_cnt_q == half_len - 8'h01) begin
      half_cnt_q <= 8'h00;
      led_q      <= ~led_q;
    end else begin
      half_cnt_q <= half_cnt_q + 8'h01;
    end
  end
  assign o_led = led_q;

  // Delay line: evaluation follows the drive by i_delay clocks
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      led_hist_q <= 8'h00;
    end else begin
      led_hist_q <= {led_hist_q[6:0], led_q};
    end
  end
  assign ref_led = (i_delay == 3'h0) ? led_q : led_hist_q[i_delay - 3'h1];

  // Blank evaluation near each delayed edge; wider dead time lowers signal
  // Only the delayed drive-high half is evaluated; delays beyond a half period alias
  assign pos    = (half_cnt_q >= 8'(i_delay)) ? half_cnt_q - 8'(i_delay) : half_cnt_q + half_len - 8'(i_delay);
  assign o_eval = i_run && ref_led && (pos >= 8'(i_dead)) && (pos + 8'(i_dead) < half_len);
endmodule // lpr_emit
`default_nettype wire

// ---- rtl/lpr_result.sv ----
// Holding register for one 16-bit measurement result
`timescale 1ns/1ns
`default_nettype none
module lpr_result (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire lpr_pkg::lpr_result_s i_res,
  output logic [15:0]               o_val
);
  import lpr_pkg::*;
  // Latest completed value held until the next one lands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_val <= 16'h0000;
    end else if (i_res.vld) begin
      o_val <= i_res.val;
    end
  end
endmodule // lpr_result
`default_nettype wire

// ---- rtl/lpr_regs.sv ----
// Result and proximity timing register bank reached through the serial byte port
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Ambient result high byte reads at 85h and low byte at 86h.
// - Ambient result bytes are read only and writes leave them unchanged.
// - Proximity result high byte reads at 87h and low byte at 88h.
// - Proximity result bytes are read only and carry bits 15:8 and 7:0.
// - Bits 1:0 of 89h pick the emitter frequency, resetting to code 2.
// - While measuring proximity the emitter is driven with that square wave.
// - Upper bits of 8Ah delay evaluation relative to the emitter drive.
// - Lowest bits of 8Ah blank evaluation around each edge.
// - A read starts with an address-only write, then reads.
// - Each byte read without a same-cycle address byte advances the register pointer by one.
module lpr_regs (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST_N,
  input  wire lpr_pkg::lpr_busreq_s I_BUS,
  input  wire lpr_pkg::lpr_result_s I_AMB,
  input  wire lpr_pkg::lpr_result_s I_PRX,
  input  wire logic                 I_PRX_RUN,
  input  wire logic [7:0]           I_IRLVL,
  output logic [7:0]                O_RDATA,
  output logic                      O_RVALID,
  output logic                      O_LED,
  output logic                      O_EVAL
);
  import lpr_pkg::*;

  logic [7:0]  ptr_q;
  logic [1:0]  freq_q;
  logic [7:0]  modt_q;
  logic [15:0] amb_val;
  logic [15:0] prx_val;
  logic [7:0]  rd_byte;
  logic        led;
  logic        eval;

  // Result holders
  lpr_result u_amb (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_res   (I_AMB),
    .o_val   (amb_val)
  );
  lpr_result u_prx (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_res   (I_PRX),
    .o_val   (prx_val)
  );

  // Register pointer: set by address byte, bumped after each read that comes without one
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ptr_q <= ADDR_AMB_HI;
    end else if (I_BUS.wr && I_BUS.addr_phase) begin
      ptr_q <= I_BUS.wdata;
    end else if (I_BUS.rd) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Writable configuration; result addresses ignore writes
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      freq_q <= FREQ_RST;
      modt_q <= MODT_RST;
    end else if (I_BUS.wr && !I_BUS.addr_phase) begin
      if (ptr_q == ADDR_FREQ) begin
        freq_q <= I_BUS.wdata[FREQ_LSB +: 2];
      end else if (ptr_q == ADDR_MODT) begin
        modt_q <= I_BUS.wdata;
      end
    end
  end

  // Read mux; unused addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == ADDR_AMB_HI) begin
      rd_byte = amb_val[15:8];
    end else if (ptr_q == ADDR_AMB_LO) begin
      rd_byte = amb_val[7:0];
    end else if (ptr_q == ADDR_PRX_HI) begin
      rd_byte = prx_val[15:8];
    end else if (ptr_q == ADDR_PRX_LO) begin
      rd_byte = prx_val[7:0];
    end else if (ptr_q == ADDR_FREQ) begin
      rd_byte = {6'h00, freq_q};
    end else if (ptr_q == ADDR_MODT) begin
      rd_byte = modt_q;
    end else if (ptr_q == ADDR_IRLVL) begin
      rd_byte = I_IRLVL; // Internal level, readable but not for normal use
    end
  end

  // Read answer registered one cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA  <= 8'h00;
      O_RVALID <= 1'b0;
    end else begin
      O_RVALID <= I_BUS.rd;
      if (I_BUS.rd) begin
        O_RDATA <= rd_byte;
      end
    end
  end

  lpr_emit u_emit (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_run   (I_PRX_RUN),
    .i_freq  (freq_q),
    .i_delay (modt_q[DELAY_LSB +: 3]),
    .i_dead  (modt_q[DEAD_LSB +: 3]),
    .o_led   (led),
    .o_eval  (eval)
  );

  // Registered emitter outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_LED  <= 1'b0;
      O_EVAL <= 1'b0;
    end else begin
      O_LED  <= led;
      O_EVAL <= eval;
    end
  end

  AST_PTR_INC: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && !I_BUS.wr |=> ptr_q == $past(ptr_q) + 8'h01) else $error("pointer did not advance");
  AST_ADDR_LOAD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.wr && I_BUS.addr_phase |=> ptr_q == $past(I_BUS.wdata)) else $error("pointer not loaded");
  AST_AMB_HI: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && ptr_q == ADDR_AMB_HI |=> O_RVALID && O_RDATA == $past(amb_val[15:8])) else $error("amb hi");
  AST_AMB_RO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_AMB.vld |=> amb_val == $past(amb_val)) else $error("ambient result changed");
  AST_PRX_LO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && ptr_q == ADDR_PRX_LO |=> O_RDATA == $past(prx_val[7:0])) else $error("prx lo");
  AST_PRX_HI: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && ptr_q == ADDR_PRX_HI |=> O_RDATA == $past(prx_val[15:8])) else $error("prx hi");
  AST_FREQ_WR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.wr && !I_BUS.addr_phase && ptr_q == ADDR_FREQ |=> freq_q == $past(I_BUS.wdata[1:0])) else $error("freq");
  AST_LED_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_PRX_RUN [*2] |=> !O_LED) else $error("emitter active while idle");
  AST_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_PRX.vld |=> prx_val == $past(I_PRX.val)) else $error("result not captured");

  // Bus shapes shared by the multi-step checks below
  sequence s_addr_wr;
    I_BUS.wr && I_BUS.addr_phase;
  endsequence

  sequence s_data_wr;
    I_BUS.wr && !I_BUS.addr_phase;
  endsequence

  sequence s_rd;
    I_BUS.rd && !I_BUS.wr;
  endsequence

  sequence s_addr_amb_then_rd;
    I_BUS.wr && I_BUS.addr_phase && I_BUS.wdata == ADDR_AMB_HI ##1 I_BUS.rd && !I_BUS.wr;
  endsequence

  // Every read is answered one cycle later
  AST_RVALID_ON: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_rd |=> O_RVALID)
    else $error("read not answered");

  // No answer without a read strobe
  AST_RVALID_OFF: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_BUS.rd |=> !O_RVALID)
    else $error("answer without read");

  // Read data stays put between reads, host may sample late
  AST_RDATA_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_BUS.rd |=> $stable(O_RDATA))
    else $error("read data moved without read");

  // Ambient low byte
  AST_AMB_LO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && ptr_q == ADDR_AMB_LO |=> O_RDATA == $past(amb_val[7:0]))
    else $error("amb lo");

  // Host writes to the ambient bytes are dropped
  AST_AMB_WR_IGN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_data_wr ##0 ((ptr_q == ADDR_AMB_HI || ptr_q == ADDR_AMB_LO) && !I_AMB.vld) |=> amb_val == $past(amb_val))
    else $error("ambient result written");

  // Host writes to the proximity bytes are dropped
  AST_PRX_WR_IGN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_data_wr ##0 ((ptr_q == ADDR_PRX_HI || ptr_q == ADDR_PRX_LO) && !I_PRX.vld) |=> prx_val == $past(prx_val))
    else $error("proximity result written");

  // Proximity value kept until the next completion
  AST_PRX_KEEP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_PRX.vld |=> prx_val == $past(prx_val))
    else $error("proximity result changed");

  // Ambient completion captured whole
  AST_AMB_CAPT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_AMB.vld |=> amb_val == $past(I_AMB.val))
    else $error("ambient result not captured");

  // Frequency code reads back in the low bits
  AST_FREQ_RD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && ptr_q == ADDR_FREQ |=> O_RDATA == {6'h00, $past(freq_q)})
    else $error("freq readback");

  // Frequency code only moves on a data write to its address
  AST_FREQ_KEEP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !(I_BUS.wr && !I_BUS.addr_phase && ptr_q == ADDR_FREQ) |=> $stable(freq_q))
    else $error("freq changed");

  // Data writes elsewhere leave the frequency code alone
  AST_FREQ_WR_ONLY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_data_wr ##0 (ptr_q != ADDR_FREQ) |=> $stable(freq_q))
    else $error("freq hit by other write");

  // Timing byte takes the written data
  AST_MODT_WR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_data_wr ##0 (ptr_q == ADDR_MODT) |=> modt_q == $past(I_BUS.wdata))
    else $error("modt write");

  // Timing byte reads back whole
  AST_MODT_RD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && ptr_q == ADDR_MODT |=> O_RDATA == $past(modt_q))
    else $error("modt readback");

  // Timing byte only moves on a data write to its address
  AST_MODT_KEEP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !(I_BUS.wr && !I_BUS.addr_phase && ptr_q == ADDR_MODT) |=> $stable(modt_q))
    else $error("modt changed");

  // Data writes elsewhere leave the timing byte alone
  AST_MODT_WR_ONLY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_data_wr ##0 (ptr_q != ADDR_MODT) |=> $stable(modt_q))
    else $error("modt hit by other write");

  // An address byte never lands in the configuration
  AST_ADDR_NO_CFG: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_addr_wr |=> $stable(modt_q) && $stable(freq_q))
    else $error("address byte stored as data");

  // Idle bus leaves the pointer alone
  AST_PTR_KEEP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_BUS.rd && !I_BUS.wr |=> $stable(ptr_q))
    else $error("pointer moved while idle");

  // Data writes do not move the pointer
  AST_PTR_DATA_WR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_data_wr ##0 !I_BUS.rd |=> $stable(ptr_q))
    else $error("pointer moved on data write");

  // Back to back reads step the pointer twice
  AST_PTR_TWO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_rd ##1 s_rd |=> ptr_q == $past(ptr_q, 2) + 8'h02)
    else $error("pointer did not step twice");

  // Pointer wraps past the top address
  AST_PTR_WRAP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_rd ##0 (ptr_q == 8'hFF) |=> ptr_q == 8'h00)
    else $error("pointer wrap");

  // Address then read returns the addressed byte
  AST_ADDR_THEN_RD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_addr_amb_then_rd |=> O_RVALID && O_RDATA == $past(amb_val[15:8]))
    else $error("addressed read");

  // Ambient pair read in one burst, low byte second
  AST_AMB_PAIR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_rd ##0 (ptr_q == ADDR_AMB_HI) ##1 s_rd |=> O_RDATA == $past(amb_val[7:0]))
    else $error("ambient burst");

  // Proximity pair read in one burst, low byte second
  AST_PRX_PAIR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_rd ##0 (ptr_q == ADDR_PRX_HI) ##1 s_rd |=> O_RDATA == $past(prx_val[7:0]))
    else $error("proximity burst");

  // Reserved level word reads through the same path
  AST_IRLVL_RD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && ptr_q == ADDR_IRLVL |=> O_RDATA == $past(I_IRLVL))
    else $error("level readback");

  // Addresses outside the bank read zero
  AST_UNMAPPED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_BUS.rd && (ptr_q < ADDR_AMB_HI || ptr_q > ADDR_IRLVL) |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");

  // Emitter only lights while a measurement runs
  AST_LED_NEEDS_RUN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_LED |-> $past(I_PRX_RUN, 2))
    else $error("emitter lit without run");

  // Evaluation window only while measuring
  AST_EVAL_NEEDS_RUN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_EVAL |-> $past(I_PRX_RUN))
    else $error("evaluation without run");

  // Evaluation closed once the run has ended
  AST_EVAL_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_PRX_RUN [*2] |=> !O_EVAL)
    else $error("evaluation while idle");
endmodule // lpr_regs
`default_nettype wire

// ---- dv/lpr_host.sv ----
// Host model: byte-level register access from the serial port side
`timescale 1ns/1ns
`default_nettype none
module lpr_host (
  input  wire logic                i_clk,
  input  wire logic                i_rvalid,
  input  wire logic [7:0]          i_rdata,
  output var  lpr_pkg::lpr_busreq_s o_bus
);
  import lpr_pkg::*;
  initial o_bus = '0;
  // One written byte; addr_phase marks a register address
  task automatic put(input logic ap, input logic [7:0] b);
    @(posedge i_clk);
    #1 o_bus = '{wr: 1'h1, rd: 1'h0, addr_phase: ap, wdata: b};
    @(posedge i_clk);
    #1 o_bus = '0;
  endtask
  // Address-only write; the reserved level register is never addressed
  task automatic sel(input logic [7:0] a);
    if (a != ADDR_IRLVL) put(1'h1, a);
  endtask
  // Read at the pointer; answer is registered, so sampled after the taking edge
  task automatic get(output logic [7:0] d, output logic v);
    @(posedge i_clk);
    #1 o_bus.rd = 1'h1;
    @(posedge i_clk);
    #1 o_bus.rd = 1'h0;
    v = i_rvalid;
    d = i_rdata;
  endtask
endmodule // lpr_host
`default_nettype wire

// ---- dv/tb_top.sv ----
// Testbench: register reads, writes and emitter timing of the result block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lpr_pkg::*;
  logic        clk   = 1'h0;
  logic        rst_n = 1'h0;
  logic        run   = 1'h0;
  lpr_busreq_s bus;
  lpr_result_s amb   = '0;
  lpr_result_s prx   = '0;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        led;
  logic        eval;
  int          fails  = 0;
  int          checks = 0;
  always #20 clk = ~clk;
  lpr_regs u_lpr_regs (.I_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus), .I_AMB(amb), .I_PRX(prx),
    .I_PRX_RUN(run), .I_IRLVL(8'h5C), .O_RDATA(rdata), .O_RVALID(rvalid), .O_LED(led), .O_EVAL(eval));
  lpr_host u_lpr_host (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_bus(bus));
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Read one byte and compare; valid must come one cycle after the request
  task automatic rchk(input string n, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    u_lpr_host.get(d, v);
    check({n, " valid"}, {7'h00, v}, 8'h01);
    check(n, d, exp);
  endtask
  // Emitter half period in clocks for one frequency code
  task automatic half(input logic [1:0] c);
    int   n;
    logic lv;
    u_lpr_host.sel(ADDR_FREQ);
    u_lpr_host.put(1'h0, {6'h00, c});
    run = 1'h1;
    for (int k = 0; k < 2; k++) begin
      lv = led;
      for (n = 0; n < 200 && led === lv; n++) begin
        @(posedge clk);
        #1;
      end
    end
    check("led half period", 8'(n), 8'(4 << c));
    if (n >= 200) final_report();
    // Window opens delay plus dead clocks after a rising drive, a half period less two dead times wide
    for (n = 0; n < 200 && led !== 1'h0; n++) begin
      @(posedge clk);
      #1;
    end
    for (n = 0; n < 200 && led !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    for (n = 0; n < 200 && eval !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    check("eval delay", 8'(n), 8'(MODT_BEST[DELAY_LSB +: 3]) + 8'(MODT_BEST[DEAD_LSB +: 3]));
    for (n = 0; n < 200 && eval === 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    check("eval width", 8'(n), 8'((4 << c) - 2 * MODT_BEST[DEAD_LSB +: 3]));
    if (n >= 200) final_report();
    run = 1'h0;
  endtask
  // Watchdog against a stuck sequence
  initial begin
    #2000000;
    fails++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'h1;
    u_lpr_host.sel(ADDR_FREQ);
    rchk("freq reset", {6'h00, FREQ_RST});
    rchk("modt reset", MODT_RST);
    $display("test reset done");
    // Completion pulses, then later values with no pulse must not show
    @(posedge clk);
    #1 amb = '{1'h1, 16'hA55A};
    prx = '{1'h1, 16'h1234};
    @(posedge clk);
    #1 amb = '{1'h0, 16'h0F0F};
    prx = '{1'h0, 16'hF0F0};
    u_lpr_host.sel(ADDR_AMB_HI);
    rchk("amb hi", 8'hA5);
    rchk("amb lo", 8'h5A);
    rchk("prx hi", 8'h12);
    rchk("prx lo", 8'h34);
    u_lpr_host.sel(ADDR_AMB_HI);
    u_lpr_host.put(1'h0, 8'hFF);
    rchk("amb hi after write", 8'hA5);
    u_lpr_host.sel(ADDR_PRX_LO);
    u_lpr_host.put(1'h0, 8'h00);
    rchk("prx lo after write", 8'h34);
    u_lpr_host.sel(8'h90);
    rchk("unmapped", 8'h00);
    $display("test results done");
    for (int c = 0; c < 4; c++) begin
      u_lpr_host.sel(ADDR_FREQ);
      u_lpr_host.put(1'h0, 8'(c));
      rchk("freq code", 8'(c));
    end
    u_lpr_host.sel(ADDR_MODT);
    u_lpr_host.put(1'h0, MODT_BEST);
    rchk("modt", MODT_BEST);
    $display("test config done");
    half(2'h0);
    half(2'h1);
    $display("test emitter done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
